//--- verilog/iab_ack.sv
`timescale 1ns/10ps
// How it works
// [R1] Acknowledge bit is status bit 0 and resets to zero.
// [R2] Transmit with checking on: returned high sets the acknowledge bit.
// [R3] Transmit with checking on: returned low clears the acknowledge bit.
// [R4] Writing zero to check enable clears the acknowledge bit.
// [R5] Receive: stored level goes onto data line in each ack slot.
// [R6] Reads give captured value when transmitting, written value otherwise.
// [R7] Software writes update the receive acknowledge level in any mode.
// [R8] Software rewrites the acknowledge level after read-modify-write of flags.
// [R9] Software clears check enable before ending transfer with stop; the testbench clears it only between transfers, after a stop.
// [R10] Acknowledge sampled or driven during ninth serial clock of a byte.
module iab_ack (
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic [iab_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [iab_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [iab_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  output logic                             irq
);
  import iab_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [1:0]        pins_s;
  logic              ack_slot;
  logic              ack_rise;
  logic              ack_val;
  logic              stop_seen;

  logic              ack_tx_r,   ack_tx_nxt;
  logic              ack_rx_r,   ack_rx_nxt;
  logic              ack_check_enable_r,     ack_check_enable_nxt;
  logic              trs_r,      trs_nxt;
  logic [EV_W-1:0]   ist_r,      ist_nxt;
  logic [EV_W-1:0]   imsk_r,     imsk_nxt;
  logic [DATA_W-1:0] rdata_r,    rdata_nxt;
  logic              sda_oe_r,   sda_oe_nxt;
  logic              sda_out_r,  sda_out_nxt;
  logic              irq_r,      irq_nxt;
  logic              wr_stat, wr_ctrl, wr_msk, rd_ist, capture;
  logic              ack_read;
  logic [EV_W-1:0]   ev;

  iab_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .d_in  ({scl_in, sda_in}),
    .d_out (pins_s)
  );

  iab_frame u_frame (
    .clock     (clock),
    .nrst      (nrst),
    .scl_s     (pins_s[1]),
    .sda_s     (pins_s[0]),
    .ack_slot  (ack_slot),
    .ack_rise  (ack_rise),
    .ack_val   (ack_val),
    .stop_seen (stop_seen)
  );

  always_comb begin
    wr_stat  = reg_wr && hit(reg_addr, OFS_STATUS);
    wr_ctrl  = reg_wr && hit(reg_addr, OFS_CTRL);
    wr_msk   = reg_wr && hit(reg_addr, OFS_IRQ_MSK);
    rd_ist   = reg_rd && hit(reg_addr, OFS_IRQ_ST);
    // Only a transmitting, checking interface listens to the slot
    capture  = ack_rise && trs_r && ack_check_enable_r;
    // [R6] Read source follows mode
    ack_read = trs_r ? ack_tx_r : ack_rx_r;

    ack_tx_nxt = ack_tx_r;
    ack_rx_nxt = ack_rx_r;
    ack_check_enable_nxt   = ack_check_enable_r;
    trs_nxt    = trs_r;
    imsk_nxt   = imsk_r;
    // [R4] Clear on check disable
    if (wr_ctrl && !reg_wdata[ACK_CHECK_ENABLE_POS]) begin
      ack_tx_nxt = 1'b0;
      ack_rx_nxt = 1'b0;
    end
    if (wr_ctrl) begin
      ack_check_enable_nxt = reg_wdata[ACK_CHECK_ENABLE_POS];
      trs_nxt  = reg_wdata[TRS_POS];
    end
    // [R7] Written level always kept
    if (wr_stat) begin
      ack_rx_nxt = reg_wdata[ACK_POS];
    end
    // [R2] [R3] Capture wins over clear
    if (capture) begin
      ack_tx_nxt = ack_val;
    end
    if (wr_msk) begin
      imsk_nxt = reg_wdata[EV_W-1:0];
    end

    ev          = EV_NONE;
    ev[EV_BYTE] = ack_rise;
    ev[EV_NACK] = capture && ack_val;
    ev[EV_STOP] = stop_seen;
    // Set wins over read clear
    ist_nxt = (rd_ist ? EV_NONE : ist_r) | ev;
    irq_nxt = |(ist_nxt & imsk_nxt);

    rdata_nxt = ZERO_WORD;
    if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS:  rdata_nxt[ACK_POS] = ack_read;
        OFS_CTRL: begin
          rdata_nxt[ACK_CHECK_ENABLE_POS] = ack_check_enable_r;
          rdata_nxt[TRS_POS]  = trs_r;
        end
        OFS_IRQ_ST:  rdata_nxt[EV_W-1:0] = ist_r;
        OFS_IRQ_MSK: rdata_nxt[EV_W-1:0] = imsk_r;
        default:     rdata_nxt = ZERO_WORD;
      endcase
    end

    // [R5] Drive ack in receive
    sda_oe_nxt  = ack_slot && !trs_r && !ack_rx_r;
    sda_out_nxt = 1'b0;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_tx_r  <= 1'b0;
      ack_rx_r  <= 1'b0;
      ack_check_enable_r    <= 1'b0;
      trs_r     <= 1'b0;
      ist_r     <= EV_NONE;
      imsk_r    <= EV_NONE;
      rdata_r   <= ZERO_WORD;
      sda_oe_r  <= 1'b0;
      sda_out_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      ack_tx_r  <= ack_tx_nxt;
      ack_rx_r  <= ack_rx_nxt;
      ack_check_enable_r    <= ack_check_enable_nxt;
      trs_r     <= trs_nxt;
      ist_r     <= ist_nxt;
      imsk_r    <= imsk_nxt;
      rdata_r   <= rdata_nxt;
      sda_oe_r  <= sda_oe_nxt;
      sda_out_r <= sda_out_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign sda_oe    = sda_oe_r;
  assign sda_out   = sda_out_r;
  assign irq       = irq_r;

  // Checks below watch only what this block drives
  logic boot_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence tx_slot_s(logic lvl);
    ack_rise && trs_r && ack_check_enable_r && (ack_val == lvl);
  endsequence

  sequence status_read_s;
    reg_rd && hit(reg_addr, OFS_STATUS);
  endsequence

  sequence rx_slot_s;
    ack_slot && !trs_r && !ack_rx_r;
  endsequence

  sequence ack_clear_s;
    wr_ctrl && !reg_wdata[ACK_CHECK_ENABLE_POS];
  endsequence

  sequence ctrl_read_s;
    reg_rd && hit(reg_addr, OFS_CTRL);
  endsequence

  ack_reset_zero_a: assert property ( // [R1]
    boot_r |-> !ack_tx_r && !ack_rx_r)
    else $error("ack bit not zero after reset");

  ack_nack_set_a: assert property ( // [R2]
    tx_slot_s(1'b1) |=> ack_tx_r)
    else $error("returned high did not set ack bit");

  ack_ack_clr_a: assert property ( // [R3]
    tx_slot_s(1'b0) |=> !ack_tx_r)
    else $error("returned low did not clear ack bit");

  ack_check_enable_clear_a: assert property ( // [R4]
    ack_clear_s ##0 !capture |=> !ack_tx_r && !ack_rx_r)
    else $error("check disable did not clear ack bit");

  capture_wins_a: assert property ( // [R4]
    ack_clear_s ##0 capture |=> ack_tx_r == $past(ack_val))
    else $error("capture lost against check disable");

  rx_drive_a: assert property ( // [R5]
    rx_slot_s ##1 rx_slot_s |-> sda_oe_r && !sda_out)
    else $error("ack not driven in receive slot");

  rx_release_a: assert property ( // [R5]
    !ack_slot ##1 !ack_slot |-> !sda_oe_r)
    else $error("data line driven outside ack slot");

  tx_no_drive_a: assert property ( // [R5]
    trs_r |=> !sda_oe_r)
    else $error("data line driven in transmit mode");

  rx_nack_free_a: assert property ( // [R5]
    ack_rx_r |=> !sda_oe_r)
    else $error("data line driven with ack level one");

  status_read_a: assert property ( // [R6]
    status_read_s |=> reg_rdata[ACK_POS] == $past(ack_read) &&
    reg_rdata[DATA_W-1:1] == '0)
    else $error("status read returned wrong ack source");

  ack_write_a: assert property ( // [R7]
    wr_stat |=> ack_rx_r == $past(reg_wdata[ACK_POS]))
    else $error("ack write not stored");

  rx_hold_a: assert property ( // [R7]
    !wr_stat && !(wr_ctrl && !reg_wdata[ACK_CHECK_ENABLE_POS]) |=> $stable(ack_rx_r))
    else $error("receive ack level changed without write");

  tx_hold_a: assert property ( // [R2]
    !capture && !(wr_ctrl && !reg_wdata[ACK_CHECK_ENABLE_POS]) |=> $stable(ack_tx_r))
    else $error("captured ack changed without slot");

  ctrl_write_a: assert property (
    wr_ctrl |=> ack_check_enable_r == $past(reg_wdata[ACK_CHECK_ENABLE_POS]) &&
    trs_r == $past(reg_wdata[TRS_POS]))
    else $error("control write not stored");

  ctrl_read_a: assert property (
    ctrl_read_s |=> reg_rdata[ACK_CHECK_ENABLE_POS] == $past(ack_check_enable_r) &&
    reg_rdata[TRS_POS] == $past(trs_r))
    else $error("control read wrong");

  mask_write_a: assert property (
    wr_msk |=> imsk_r == $past(reg_wdata[EV_W-1:0]))
    else $error("mask write not stored");

  mask_read_a: assert property (
    reg_rd && hit(reg_addr, OFS_IRQ_MSK) |=>
    reg_rdata[EV_W-1:0] == $past(imsk_r))
    else $error("mask read wrong");

  ist_read_a: assert property (
    rd_ist |=> reg_rdata[EV_W-1:0] == $past(ist_r))
    else $error("event status read wrong");

  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == ZERO_WORD)
    else $error("read data not zero outside read answer");

  rdata_unmapped_a: assert property (
    reg_rd && (reg_addr > OFS_IRQ_MSK) |=> reg_rdata == ZERO_WORD)
    else $error("unmapped read not zero");

  irq_level_a: assert property (
    irq_r == |(ist_r & imsk_r))
    else $error("interrupt level does not follow status and mask");

  nack_flag_a: assert property ( // [R2]
    tx_slot_s(1'b1) |=> ist_r[EV_NACK])
    else $error("not-ack event not flagged");

  byte_flag_a: assert property ( // [R10]
    ack_rise |=> ist_r[EV_BYTE])
    else $error("ack slot event not flagged");

  stop_flag_a: assert property (
    stop_seen |=> ist_r[EV_STOP])
    else $error("stop event not flagged");

  ist_clear_a: assert property (
    rd_ist && (ev == EV_NONE) |=> ist_r == EV_NONE)
    else $error("event status not cleared by read");

  ist_sticky_a: assert property (
    !rd_ist |=> (ist_r & $past(ist_r)) == $past(ist_r))
    else $error("event status bit lost without read");
endmodule

//--- verilog/iab_pkg.sv
package iab_pkg;
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 8;
  localparam int          CNT_W       = 4;
  localparam int          EV_W        = 3;
  // Register offsets
  localparam logic [3:0]  OFS_STATUS  = 4'h0;
  localparam logic [3:0]  OFS_CTRL    = 4'h1;
  localparam logic [3:0]  OFS_IRQ_ST  = 4'h2;
  localparam logic [3:0]  OFS_IRQ_MSK = 4'h3;
  // Field positions
  localparam int          ACK_POS     = 0;
  localparam int          ACK_CHECK_ENABLE_POS    = 0;
  localparam int          TRS_POS     = 1;
  localparam int          EV_BYTE     = 0;
  localparam int          EV_NACK     = 1;
  localparam int          EV_STOP     = 2;
  // Reset values and counts
  localparam logic [7:0]  ZERO_WORD   = 8'h00;
  localparam logic [2:0]  EV_NONE     = 3'h0;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  localparam logic [3:0]  ACK_SLOT    = 4'h8;
  localparam logic [1:0]  PIN_IDLE    = 2'h3;
endpackage

//--- verilog/iab_sync.sv
`timescale 1ns/10ps
module iab_sync #(
  parameter int W = 2
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] stab_r;
  logic [W-1:0] stab_nxt;

  // Idle bus lines are high, so both stages reset high
  always_comb begin
    meta_nxt = d_in;
    stab_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '1;
      stab_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      stab_r <= stab_nxt;
    end
  end

  assign d_out = stab_r;
endmodule

//--- verilog/iab_frame.sv
`timescale 1ns/10ps
module iab_frame (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  scl_s,
  input  wire logic                  sda_s,
  output logic                       ack_slot,
  output logic                       ack_rise,
  output logic                       ack_val,
  output logic                       stop_seen
);
  import iab_pkg::*;

  logic             scl_d_r,  scl_d_nxt;
  logic             sda_d_r,  sda_d_nxt;
  logic             busy_r,   busy_nxt;
  logic [CNT_W-1:0] cnt_r,    cnt_nxt;
  logic             slot_r,   slot_nxt;
  logic             rise_r,   rise_nxt;
  logic             val_r,    val_nxt;
  logic             stop_r,   stop_nxt;
  logic             skip_r,   skip_nxt;
  logic             scl_rise, scl_fall, start_c, stop_c;

  always_comb begin
    scl_rise  = scl_s & ~scl_d_r;
    scl_fall  = ~scl_s & scl_d_r;
    start_c   = scl_s & scl_d_r & sda_d_r & ~sda_s;
    stop_c    = scl_s & scl_d_r & ~sda_d_r & sda_s;
    scl_d_nxt = scl_s;
    sda_d_nxt = sda_s;
    busy_nxt  = busy_r;
    cnt_nxt   = cnt_r;
    skip_nxt  = skip_r;
    if (start_c) begin
      busy_nxt = 1'b1;
      cnt_nxt  = CNT_ZERO;
      skip_nxt = 1'b1;
    end else if (stop_c) begin
      busy_nxt = 1'b0;
      cnt_nxt  = CNT_ZERO;
      skip_nxt = 1'b0;
    end else if (busy_r && scl_fall) begin
      // Fall that follows start is no bit
      if (skip_r) begin
        skip_nxt = 1'b0;
      end else begin
        // [R10] Ninth clock slot
        cnt_nxt = (cnt_r == ACK_SLOT) ? CNT_ZERO : cnt_r + CNT_ONE;
      end
    end
    slot_nxt = busy_nxt && (cnt_nxt == ACK_SLOT);
    // [R10] Sample on ninth rise
    rise_nxt = busy_r && scl_rise && (cnt_r == ACK_SLOT);
    val_nxt  = rise_nxt ? sda_s : val_r;
    stop_nxt = stop_c;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_r  <= 1'b0;
      cnt_r   <= CNT_ZERO;
      slot_r  <= 1'b0;
      rise_r  <= 1'b0;
      val_r   <= 1'b1;
      stop_r  <= 1'b0;
      skip_r  <= 1'b0;
    end else begin
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
      busy_r  <= busy_nxt;
      cnt_r   <= cnt_nxt;
      slot_r  <= slot_nxt;
      rise_r  <= rise_nxt;
      val_r   <= val_nxt;
      stop_r  <= stop_nxt;
      skip_r  <= skip_nxt;
    end
  end

  assign ack_slot  = slot_r;
  assign ack_rise  = rise_r;
  assign ack_val   = val_r;
  assign stop_seen = stop_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence ninth_fall_s;
    busy_r && scl_fall && !start_c && !stop_c && !skip_r &&
    (cnt_r == ACK_SLOT);
  endsequence

  ack_slot_wrap_a: assert property ( // [R10]
    ninth_fall_s |=> (cnt_r == CNT_ZERO) ##0 !slot_r)
    else $error("ack slot did not end on ninth falling edge");
endmodule

//--- tb/iab_bus_model.sv
`timescale 1ns/10ps
module iab_bus_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  localparam time HALF = 100;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves mid low phase so it never looks like start or stop
  task automatic xfer(input logic [7:0] d, input logic drv, input logic ret,
                      output logic seen);
    sda_low = 1'b1;
    #HALF scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(HALF/2) sda_low = ~d[i];
      #(HALF/2) scl = 1'b1;
      #HALF scl = 1'b0;
    end
    #(HALF/2) sda_low = drv & ~ret;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) seen = sda_line;
    #(HALF/2) scl = 1'b0;
    #(HALF/2) sda_low = 1'b1;
    #(HALF/2) scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
endmodule

//--- tb/i2c_acknowledge_bit_logic_tb.sv
`timescale 1ns/10ps
module i2c_acknowledge_bit_logic_tb;
  import iab_pkg::*;
  logic              clock, nrst, reg_wr, reg_rd;
  logic              sda_out, sda_oe, irq, scl, sda_low, seen;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
  wire               sda_line;
  int                err_total, compares;
  // Open drain with pull-up: released line reads high
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  iab_ack i_dut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
  );
  iab_bus_model i_bus (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: reg got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: bit got %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    chk(rv, exp);
  endtask
  // Transmit mode never drives, so line shows the returned level
  task automatic byte_x(input logic drv, input logic ret, input logic exp);
    i_bus.xfer(8'hA5, drv, ret, seen);
    chk_bit(seen, exp);
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    give_verdict();
  end
  initial begin
    nrst      = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    err_total = 0;
    compares  = 0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 4; a++) rchk(a[3:0], 8'h00);
    wr(4'h5, 8'hFF);
    rchk(4'h5, 8'h00);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_STATUS, 8'h00);
    byte_x(1'b0, 1'b0, 1'b0);
    wr(OFS_STATUS, 8'h01);
    byte_x(1'b0, 1'b0, 1'b1);
    rchk(OFS_STATUS, 8'h01);
    wr(OFS_CTRL, 8'h03);
    byte_x(1'b1, 1'b1, 1'b1);
    rchk(OFS_STATUS, 8'h01);
    wr(OFS_STATUS, 8'h00);
    rchk(OFS_STATUS, 8'h01);
    byte_x(1'b1, 1'b0, 1'b0);
    rchk(OFS_STATUS, 8'h00);
    byte_x(1'b1, 1'b1, 1'b1);
    wr(OFS_CTRL, 8'h01);
    rchk(OFS_STATUS, 8'h00);
    byte_x(1'b0, 1'b0, 1'b0);
    wr(OFS_CTRL, 8'h03);
    byte_x(1'b1, 1'b1, 1'b1);
    wr(OFS_CTRL, 8'h02);
    rchk(OFS_STATUS, 8'h00);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_STATUS, 8'h01);
    wr(OFS_CTRL, 8'h00);
    byte_x(1'b0, 1'b0, 1'b0);
    // Interrupt: masked, unmasked, cleared by read
    wr(OFS_CTRL, 8'h03);
    wr(OFS_IRQ_MSK, 8'h00);
    rd(OFS_IRQ_ST);
    byte_x(1'b1, 1'b1, 1'b1);
    chk_bit(irq, 1'b0);
    wr(OFS_IRQ_MSK, 8'h02);
    repeat (2) @(posedge clock);
    #1 chk_bit(irq, 1'b1);
    rchk(OFS_IRQ_MSK, 8'h02);
    rchk(OFS_IRQ_ST, 8'h07);
    repeat (2) @(posedge clock);
    #1 chk_bit(irq, 1'b0);
    rchk(OFS_IRQ_ST, 8'h00);
    // Flag update, then level written again
    rd(OFS_STATUS);
    wr(OFS_STATUS, rv);
    wr(OFS_STATUS, 8'h00);
    // Check enable dropped after last stop
    wr(OFS_CTRL, 8'h00);
    rchk(OFS_STATUS, 8'h00);
    give_verdict();
  end
endmodule
